// *** src/rtc_pkg.sv ***
// Constants and types shared by the real-time clock and its backup bank
`default_nettype none
package rtc_pkg;
	localparam int unsigned RTC_CNT_W     = 32;
	localparam int unsigned RTC_PRESC_W   = 20;
	localparam int unsigned RTC_BKP_N     = 42;
	localparam int unsigned RTC_BKP_W     = 16;
	localparam int unsigned RTC_BKP_AW    = 6;
	localparam int unsigned RTC_HSE_DIV   = 128;
	localparam int unsigned RTC_HSE_DW    = 7;
	// 512 Hz from 32.768 kHz: toggle every 32 source ticks
	localparam int unsigned RTC_CAL_HALF  = 32;
	localparam int unsigned RTC_CAL_DW    = 5;
	localparam real         RTC_LSE_KHZ   = 32.768;
	localparam real         RTC_CAL_HZ    = 512.0;
	// Reload value: divide by 32768 gives one second from the 32.768 kHz source
	localparam logic [19:0] RTC_PRESC_RST = 20'h0_7FFF;
	localparam logic [31:0] RTC_CNT_RST   = 32'h0000_0000;
	localparam logic [31:0] RTC_CMP_RST   = 32'hFFFF_FFFF;

	typedef enum logic [1:0] {
		RTC_SRC_LSE = 2'b00,
		RTC_SRC_LSI = 2'b01,
		RTC_SRC_HSE = 2'b10
	} rtc_src_e;

	function automatic logic rtc_rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction
endpackage
`default_nettype wire

// *** src/rtc_bkp_if.sv ***
// Interface between the clock core and its backup register bank
`default_nettype none
interface rtc_bkp_if;
	import rtc_pkg::*;
	logic [RTC_BKP_AW-1:0] addr;
	logic [RTC_BKP_W-1:0]  wdata;
	logic                  we;
	logic [RTC_BKP_W-1:0]  rdata;

	modport core (output addr, output wdata, output we, input rdata);
	modport bank (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// *** src/rtc_bkp_bank.sv ***
// Backup register bank: forty-two 16-bit words, untouched by any reset
`default_nettype none
module rtc_bkp_bank
	import rtc_pkg::*;
#(
	parameter int unsigned NUM_REGS = RTC_BKP_N
) (
	input  wire logic mclk,
	input  wire logic ce,
	rtc_bkp_if.bank   bkp
);
	logic [RTC_BKP_W-1:0] mem [NUM_REGS];
	logic [RTC_BKP_W-1:0] rdata_r;
	logic [RTC_BKP_W-1:0] rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (32'(bkp.addr) < NUM_REGS) begin
			rdata_nxt = mem[bkp.addr];
		end else begin
			rdata_nxt = '0;
		end
	end

	// No reset branch at all, so contents live through every reset [RULE_01] [RULE_02]
	always_ff @(posedge mclk) begin
		if (ce) begin
			rdata_r <= rdata_nxt;
			if (bkp.we && 32'(bkp.addr) < NUM_REGS) begin
				mem[bkp.addr] <= bkp.wdata;
			end
		end
	end

	assign bkp.rdata = rdata_r;
endmodule
`default_nettype wire

// *** src/rtc_core.sv ***
// Real-time clock: source select, prescaler, counter, alarm, calibration out
//
// Notes on behaviour
// [RULE_01] Forty-two 16-bit backup words, 84 bytes.
// [RULE_02] Backup words survive every reset and standby.
// [RULE_03] Counters run always; periodic and alarm interrupts. Here they hold while ce is low or src_sel is 3.
// [RULE_04] Source: external slow, internal RC, fast/128.
// [RULE_05] 512 Hz calibration clock on a pin.
// [RULE_06] Loadable 32-bit counter; alarm on compare equal.
// [RULE_07] 20-bit prescaler, default divide by 32768.
// [RULE_08] Sticky flags set by events, cleared by software.
`default_nettype none
module rtc_core
	import rtc_pkg::*;
#(
	parameter int unsigned PRESC_W = RTC_PRESC_W,
	parameter int unsigned CNT_W   = RTC_CNT_W
) (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic                  lse_clk,
	input  wire logic                  lsi_clk,
	input  wire logic                  hse_clk,
	input  wire logic [1:0]            src_sel,
	input  wire logic                  presc_we,
	input  wire logic [PRESC_W-1:0]    presc_wdata,
	input  wire logic                  cnt_we,
	input  wire logic [CNT_W-1:0]      cnt_wdata,
	input  wire logic                  cmp_we,
	input  wire logic [CNT_W-1:0]      cmp_wdata,
	input  wire logic                  sec_clr,
	input  wire logic                  alm_clr,
	input  wire logic                  cal_en,
	input  wire logic [RTC_BKP_AW-1:0] bkp_addr,
	input  wire logic [RTC_BKP_W-1:0]  bkp_wdata,
	input  wire logic                  bkp_we,
	output logic [RTC_BKP_W-1:0]       bkp_rdata,
	output logic [CNT_W-1:0]           cnt_value,
	output logic                       sec_flag,
	output logic                       alm_flag,
	output logic                       cal_out
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: bit 0 lse, bit 1 lsi, bit 2 hse
	logic [2:0] meta_r;
	logic [2:0] sync_r;
	logic [2:0] prev_r;
	logic [2:0] prev_nxt;

	always_comb begin
		prev_nxt = sync_r;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else if (ce) begin
			meta_r <= {hse_clk, lsi_clk, lse_clk};
			sync_r <= meta_r;
			prev_r <= prev_nxt;
		end
	end

	logic lse_edge;
	logic lsi_edge;
	logic hse_edge;

	assign lse_edge = rtc_rise(sync_r[0], prev_r[0]);
	assign lsi_edge = rtc_rise(sync_r[1], prev_r[1]);
	assign hse_edge = rtc_rise(sync_r[2], prev_r[2]);

	////////////////////////////////////////////////////////////////////////
	// Fast source pre-divider and source selection
	// The fast clock must stay well below mclk/2 to be sampled at all.
	logic [RTC_HSE_DW-1:0] hdiv_r;
	logic [RTC_HSE_DW-1:0] hdiv_nxt;
	logic                  hse_tick;
	logic                  src_tick;

	always_comb begin
		hdiv_nxt = hdiv_r;
		hse_tick = 1'b0;
		if (hse_edge) begin
			hdiv_nxt = hdiv_r + 1'b1;
			hse_tick = (32'(hdiv_r) == RTC_HSE_DIV - 1); // [RULE_04]
		end
	end

	always_comb begin
		case (rtc_src_e'(src_sel)) // [RULE_04]
			RTC_SRC_LSE: src_tick = lse_edge;
			RTC_SRC_LSI: src_tick = lsi_edge;
			RTC_SRC_HSE: src_tick = hse_tick;
			default:     src_tick = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			hdiv_r <= '0;
		end else if (ce) begin
			hdiv_r <= hdiv_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler: divides by reload plus one
	logic [PRESC_W-1:0] reload_r;
	logic [PRESC_W-1:0] reload_nxt;
	logic [PRESC_W-1:0] pdiv_r;
	logic [PRESC_W-1:0] pdiv_nxt;
	logic               tb_tick;

	always_comb begin
		reload_nxt = presc_we ? presc_wdata : reload_r; // [RULE_07]
		pdiv_nxt   = pdiv_r;
		tb_tick    = 1'b0;
		if (presc_we) begin
			// Restart so the new period takes effect cleanly
			pdiv_nxt = presc_wdata;
		end else if (src_tick) begin
			if (pdiv_r == '0) begin
				pdiv_nxt = reload_r; // [RULE_07]
				tb_tick  = 1'b1;
			end else begin
				pdiv_nxt = pdiv_r - 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			reload_r <= PRESC_W'(RTC_PRESC_RST);
			pdiv_r   <= PRESC_W'(RTC_PRESC_RST);
		end else if (ce) begin
			reload_r <= reload_nxt;
			pdiv_r   <= pdiv_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter, compare and alarm detection
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] cmp_r;
	logic [CNT_W-1:0] cmp_nxt;
	logic             cnt_chg;
	logic             alm_hit;

	always_comb begin
		cnt_nxt = cnt_r;
		cnt_chg = 1'b0;
		if (cnt_we) begin
			cnt_nxt = cnt_wdata; // [RULE_06]
			cnt_chg = 1'b1;
		end else if (tb_tick) begin
			cnt_nxt = cnt_r + 1'b1; // [RULE_03] [RULE_06]
			cnt_chg = 1'b1;
		end
		cmp_nxt = cmp_we ? cmp_wdata : cmp_r;
		// Fires once as the counter reaches the compare value, not every cycle
		alm_hit = cnt_chg && (cnt_nxt == cmp_nxt); // [RULE_06]
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_r <= CNT_W'(RTC_CNT_RST);
			cmp_r <= CNT_W'(RTC_CMP_RST);
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			cmp_r <= cmp_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky interrupt flags; an event in the clear cycle wins
	logic sec_r;
	logic sec_nxt;
	logic alm_r;
	logic alm_nxt;

	always_comb begin
		sec_nxt = tb_tick | (sec_r & ~sec_clr); // [RULE_08] [RULE_03]
		alm_nxt = alm_hit | (alm_r & ~alm_clr); // [RULE_08] [RULE_03]
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sec_r <= 1'b0;
			alm_r <= 1'b0;
		end else if (ce) begin
			sec_r <= sec_nxt;
			alm_r <= alm_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calibration output: source divided by 64, ahead of the prescaler
	logic [RTC_CAL_DW-1:0] cdiv_r;
	logic [RTC_CAL_DW-1:0] cdiv_nxt;
	logic                  cal_r;
	logic                  cal_nxt;

	always_comb begin
		cdiv_nxt = cdiv_r;
		cal_nxt  = cal_r;
		if (!cal_en) begin
			cdiv_nxt = '0;
			cal_nxt  = 1'b0;
		end else if (src_tick) begin
			cdiv_nxt = cdiv_r + 1'b1;
			if (32'(cdiv_r) == RTC_CAL_HALF - 1) begin
				cal_nxt = ~cal_r; // [RULE_05]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cdiv_r <= '0;
			cal_r  <= 1'b0;
		end else if (ce) begin
			cdiv_r <= cdiv_nxt;
			cal_r  <= cal_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Backup bank
	rtc_bkp_if bkp ();

	assign bkp.addr  = bkp_addr;
	assign bkp.wdata = bkp_wdata;
	assign bkp.we    = bkp_we;

	rtc_bkp_bank #(
		.NUM_REGS (RTC_BKP_N)
	) u_bank (
		.mclk (mclk),
		.ce   (ce),
		.bkp  (bkp.bank) // [RULE_01] [RULE_02]
	);

	assign bkp_rdata = bkp.rdata;
	assign cnt_value = cnt_r;
	assign sec_flag  = sec_r;
	assign alm_flag  = alm_r;
	assign cal_out   = cal_r;
endmodule
`default_nettype wire

// *** sim/rtc_core_assertions.sv ***
// Port checker for the real-time clock core
`default_nettype none
module rtc_core_assertions #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic             mclk,
	input wire logic             srst,
	input wire logic             ce,
	input wire logic             cnt_we,
	input wire logic [CNT_W-1:0] cnt_wdata,
	input wire logic             sec_clr,
	input wire logic             alm_clr,
	input wire logic             cal_en,
	input wire logic [CNT_W-1:0] cnt_value,
	input wire logic             sec_flag,
	input wire logic             alm_flag,
	input wire logic             cal_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	AST_CNT_LOAD: assert property (
		ce && cnt_we |=> cnt_value == $past(cnt_wdata))
		else $error("counter load not taken");
	AST_CNT_STEP: assert property (
		ce && !cnt_we |=> cnt_value - $past(cnt_value) <= 32'h0000_0001)
		else $error("counter moved by more than one");
	AST_SEC_SET: assert property (
		ce && !cnt_we ##1 cnt_value == $past(cnt_value) + 32'h0000_0001
		|-> sec_flag) else $error("tick without periodic flag");
	// A tick in the clear cycle must win, so the counter tells us which
	AST_SEC_CLR: assert property (
		ce && sec_clr && !cnt_we
		|=> sec_flag == (cnt_value != $past(cnt_value)))
		else $error("periodic flag clear wrong");
	AST_ALM_HOLD: assert property (
		alm_flag && !alm_clr |=> alm_flag)
		else $error("alarm flag dropped by itself");
	AST_ALM_CAUSE: assert property (
		$rose(alm_flag) |-> $past(cnt_we) || cnt_value != $past(cnt_value))
		else $error("alarm without counter change");
	AST_CAL_OFF: assert property (
		ce && !cal_en ##1 ce && !cal_en |-> !cal_out)
		else $error("calibration output active while disabled");
	AST_FREEZE: assert property (
		!ce |=> $stable(cnt_value) && $stable(sec_flag) && $stable(alm_flag))
		else $error("state moved with clock enable low");
endmodule
bind rtc_core rtc_core_assertions #(
	.CNT_W (CNT_W)
) i_rtc_core_assertions (
	.mclk      (mclk),
	.srst      (srst),
	.ce        (ce),
	.cnt_we    (cnt_we),
	.cnt_wdata (cnt_wdata),
	.sec_clr   (sec_clr),
	.alm_clr   (alm_clr),
	.cal_en    (cal_en),
	.cnt_value (cnt_value),
	.sec_flag  (sec_flag),
	.alm_flag  (alm_flag),
	.cal_out   (cal_out)
);
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the real-time clock core
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import rtc_pkg::*;
	logic        mclk = 0, srst = 1, ce = 1, cal_en = 0;
	logic        lse_clk = 0, lsi_clk = 0, hse_clk = 0;
	logic        presc_we = 0, cnt_we = 0, cmp_we = 0, bkp_we = 0;
	logic        sec_clr = 0, alm_clr = 0;
	logic [1:0]  src_sel = 2'h0;
	logic [5:0]  bkp_addr = 6'h00;
	logic [31:0] wd = 32'h0000_0000, cnt_value;
	logic [15:0] bkp_rdata;
	logic        sec_flag, alm_flag, cal_out;
	int          gap = 1, num_errors = 0, samples_checked = 0;
	int          ad[3] = '{0, 41, 42};

	rtc_core i_rtc_core (
		.mclk (mclk), .srst (srst), .ce (ce),
		.lse_clk (lse_clk), .lsi_clk (lsi_clk), .hse_clk (hse_clk),
		.src_sel (src_sel), .presc_we (presc_we),
		.presc_wdata (wd[19:0]), .cnt_we (cnt_we), .cnt_wdata (wd),
		.cmp_we (cmp_we), .cmp_wdata (wd),
		.sec_clr (sec_clr), .alm_clr (alm_clr), .cal_en (cal_en),
		.bkp_addr (bkp_addr), .bkp_wdata (wd[15:0]), .bkp_we (bkp_we),
		.bkp_rdata (bkp_rdata), .cnt_value (cnt_value),
		.sec_flag (sec_flag), .alm_flag (alm_flag), .cal_out (cal_out)
	);

	always #25 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic wr(ref logic we, input logic [31:0] d);
		wd = d;
		we = 1;
		cyc(1);
		we = 0;
		// Let an edge pass so a following write never re-raises in one step
		cyc(1);
	endtask
	// Only the selected pin toggles (all three for the reserved code 3), so a wrong mux shows up as no tick
	task automatic edges(input int n);
		repeat (n) begin
			{hse_clk, lsi_clk, lse_clk} = src_sel == 2'h3 ? 3'h7 : 3'h1 << src_sel;
			cyc(1);
			{hse_clk, lsi_clk, lse_clk} = 3'h0;
			cyc(gap);
		end
		cyc(5);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_default();
		edges(32767);
		chk(cnt_value, 32'h0000_0000);
		edges(1);
		chk(cnt_value, 32'h0000_0001);
		chk(sec_flag, 1);
		wr(sec_clr, 0);
		chk(sec_flag, 0);
		$display("default period done");
	endtask
	task automatic t_src();
		wr(presc_we, 3);
		src_sel = 2'h1;
		edges(3);
		chk(cnt_value, 32'h0000_0001);
		edges(1);
		chk(cnt_value, 32'h0000_0002);
		src_sel = 2'h2;
		gap = 4;
		wr(presc_we, 0);
		edges(127);
		chk(cnt_value, 32'h0000_0002);
		edges(1);
		chk(cnt_value, 32'h0000_0003);
		gap = 1;
		src_sel = 2'h3;
		edges(4);
		chk(cnt_value, 32'h0000_0003);
		src_sel = 2'h0;
		ce = 0;
		edges(4);
		chk(cnt_value, 32'h0000_0003);
		ce = 1;
		$display("source select done");
	endtask
	task automatic t_alarm();
		wr(cmp_we, 32'h0000_000A);
		wr(cnt_we, 32'h0000_0009);
		chk(alm_flag, 0);
		edges(1);
		chk(cnt_value, 32'h0000_000A);
		chk(alm_flag, 1);
		cyc(3);
		chk(alm_flag, 1);
		wr(alm_clr, 0);
		chk(alm_flag, 0);
		wr(cnt_we, 32'hFFFF_FFFF);
		edges(1);
		chk(cnt_value, 32'h0000_0000);
		$display("alarm done");
	endtask
	task automatic t_cal();
		cal_en = 1;
		edges(31);
		chk(cal_out, 0);
		edges(1);
		chk(cal_out, 1);
		cal_en = 0;
		cyc(2);
		chk(cal_out, 0);
		$display("calibration done");
	endtask
	task automatic t_bkp();
		logic [31:0] exp_w;
		foreach (ad[i]) begin
			bkp_addr = 6'(ad[i]);
			wr(bkp_we, 32'h0000_5A00 + ad[i]);
		end
		srst = 1;
		cyc(3);
		srst = 0;
		chk(cnt_value, 32'h0000_0000);
		foreach (ad[i]) begin
			bkp_addr = 6'(ad[i]);
			cyc(2);
			exp_w = ad[i] < RTC_BKP_N ? 32'h0000_5A00 + ad[i] : 32'h0000_0000;
			chk(bkp_rdata, exp_w);
		end
		$display("backup bank done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(6);
		srst = 0;
		t_default();
		t_src();
		t_alarm();
		t_cal();
		t_bkp();
		give_verdict();
	end
	// Default-period test alone needs about 66k cycles
	initial begin
		cyc(90000);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
